// file: rtl/lpc_consts.svh
// Constants of the line printer control: offsets, fields, resets, timing
`ifndef LPC_CONSTS_SVH
`define LPC_CONSTS_SVH

`define LPC_ADDR_CMD 12'h000
`define LPC_ADDR_AC 12'h004
`define LPC_ADDR_STATUS 12'h008
`define LPC_ADDR_ISTAT 12'h00C
`define LPC_ADDR_IMASK 12'h010

`define LPC_OP_IOT 3'h6
`define LPC_DEV_SEL 6'h36
`define LPC_CLR_ALL_CODE 12'hC07
`define LPC_SUB_SKF 3'h1
`define LPC_SUB_CLF 3'h2
`define LPC_SUB_SKE 3'h3
`define LPC_SUB_LOAD 3'h4
`define LPC_SUB_SIE 3'h5
`define LPC_SUB_CLF_LOAD 3'h6
`define LPC_SUB_CIE 3'h7

`define LPC_ST_FLAG 0
`define LPC_ST_IE 1
`define LPC_ST_SKIP 2
`define LPC_ST_READY 3
`define LPC_ST_STROBE 4
`define LPC_ST_BUSY 5

`define LPC_IRQ_FLAG 0
`define LPC_IRQ_ERR 1
`define LPC_IRQ_DONE 2
`define LPC_IRQ_W 3

`define LPC_AC_RST 12'h000
`define LPC_CODE_RST 12'h000
`define LPC_MASK_RST 3'h0
`define LPC_BUF_RST 7'h00

`define LPC_CLK_NS 4
`define LPC_TP_NS 100
`define LPC_TP_CYC ((`LPC_TP_NS + `LPC_CLK_NS - 1) / `LPC_CLK_NS)
`define LPC_TP_CNT_W 5

`endif

// file: rtl/lpc_pkg.sv
// Types of the line printer control
package lpc_pkg;

  typedef enum logic [2:0] {
    LPC_IDLE = 3'b000,
    LPC_TP1 = 3'b001,
    LPC_TP2 = 3'b010,
    LPC_TP_LOAD = 3'b011,
    LPC_TRAIL = 3'b100
  } lpc_state_t;

endpackage

// file: rtl/lpc_sync.sv
// Two flip-flop synchroniser for printer pins
`timescale 1ns/1ns
module lpc_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and synchronised levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= d[i];
          sync_r <= meta_r;
        end
      end
      assign q[i] = sync_r;
    end
  endgenerate

endmodule

// file: rtl/lpc_line_printer_ctl.sv
// Line printer control with APB registers and printer port
`timescale 1ns/1ns
`include "lpc_consts.svh"
module lpc_line_printer_ctl
  import lpc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System side
  input wire logic sys_init,
  output logic irq,
  output logic bus_irq_n,
  output logic iot_skip,
  // Printer side
  input wire logic ready,
  input wire logic char_request,
  output logic [6:0] char_data,
  output logic data_strobe
);

  localparam logic [`LPC_TP_CNT_W-1:0] TP_LAST =
    `LPC_TP_CNT_W'(`LPC_TP_CYC - 1);

  // Synchronised printer lines
  logic [1:0] pins_s;
  logic ready_s;
  logic req_s;

  lpc_sync #(
    .W(2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({ready, char_request}),
    .q(pins_s)
  );

  assign ready_s = pins_s[1];
  assign req_s = pins_s[0];

  // State
  lpc_state_t state_r, state_nxt;
  logic [`LPC_TP_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [11:0] code_r, code_nxt;
  logic skip_r, skip_nxt;
  logic iot_skip_r, iot_skip_nxt;
  logic flag_r, flag_nxt;
  logic ie_r, ie_nxt;
  logic [6:0] buf_r, buf_nxt;
  logic strobe_r, strobe_nxt;
  logic req_d_r, req_d_nxt;
  logic rdy_d_r, rdy_d_nxt;
  logic [11:0] ac_r, ac_nxt;
  logic [`LPC_IRQ_W-1:0] istat_r, istat_nxt;
  logic [`LPC_IRQ_W-1:0] imask_r, imask_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  // Decode and timing terms
  logic busy;
  logic tp_tick;
  logic tick1;
  logic tick3;
  logic tick_end;
  logic dev_sel;
  logic is_clr_all;
  logic [2:0] sub;
  logic is_load;
  logic req_rise;
  logic req_fall;
  logic rdy_fall;
  logic access;
  logic addr_ok;
  logic cmd_hit;
  logic wr_ok;
  logic cmd_accept;
  logic [31:0] rd_val;
  logic [31:0] st_word;

  assign busy = (state_r != LPC_IDLE);
  assign tp_tick = busy && (cnt_r == TP_LAST);
  assign tick1 = tp_tick && (state_r == LPC_TP1);
  assign tick3 = tp_tick && (state_r == LPC_TP_LOAD);
  assign tick_end = tp_tick && (state_r == LPC_TRAIL);
  assign dev_sel = (code_r[11:9] == `LPC_OP_IOT) &&
                   (code_r[8:3] == `LPC_DEV_SEL);
  assign is_clr_all = (code_r == `LPC_CLR_ALL_CODE);
  assign sub = code_r[2:0];
  assign is_load = dev_sel && ((sub == `LPC_SUB_LOAD) ||
                               (sub == `LPC_SUB_CLF_LOAD));
  assign req_rise = req_s && !req_d_r;
  assign req_fall = !req_s && req_d_r;
  assign rdy_fall = !ready_s && rdy_d_r;

  // APB decode
  assign access = psel && penable;
  assign addr_ok = (paddr == `LPC_ADDR_CMD) || (paddr == `LPC_ADDR_AC) ||
                   (paddr == `LPC_ADDR_STATUS) ||
                   (paddr == `LPC_ADDR_ISTAT) ||
                   (paddr == `LPC_ADDR_IMASK);
  assign cmd_hit = psel && pwrite && (paddr == `LPC_ADDR_CMD);
  assign pready = !(cmd_hit && busy);
  assign pslverr = access && !addr_ok;
  assign wr_ok = access && pwrite && pready && addr_ok;
  assign cmd_accept = wr_ok && (paddr == `LPC_ADDR_CMD);

  // Instruction sequencer: three time pulses, then the trailing edge
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = '0;
    code_nxt = code_r;
    skip_nxt = skip_r;
    iot_skip_nxt = 1'b0;
    if (busy && !tp_tick) begin
      cnt_nxt = cnt_r + `LPC_TP_CNT_W'(1);
    end
    case (state_r)
      LPC_IDLE: begin
        if (cmd_accept) begin
          code_nxt = pwdata[11:0];
          skip_nxt = 1'b0;
          state_nxt = LPC_TP1;
        end
      end
      LPC_TP1: begin
        if (tick1) begin
          state_nxt = LPC_TP2;
          if (dev_sel && (sub == `LPC_SUB_SKF)) begin
            skip_nxt = flag_r;
          end else if (dev_sel && (sub == `LPC_SUB_SKE)) begin
            skip_nxt = !ready_s;
          end
        end
      end
      LPC_TP2: begin
        if (tp_tick) begin
          state_nxt = LPC_TP_LOAD;
        end
      end
      LPC_TP_LOAD: begin
        if (tp_tick) begin
          state_nxt = LPC_TRAIL;
        end
      end
      LPC_TRAIL: begin
        if (tp_tick) begin
          state_nxt = LPC_IDLE;
          iot_skip_nxt = skip_r;
        end
      end
      default: begin
        state_nxt = LPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= LPC_IDLE;
      cnt_r <= '0;
      code_r <= `LPC_CODE_RST;
      skip_r <= 1'b0;
      iot_skip_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      code_r <= code_nxt;
      skip_r <= skip_nxt;
      iot_skip_r <= iot_skip_nxt;
    end
  end

  // Flag, interrupt enable, character buffer and strobe
  always_comb begin
    flag_nxt = flag_r;
    ie_nxt = ie_r;
    buf_nxt = buf_r;
    strobe_nxt = strobe_r;
    req_d_nxt = req_s;
    rdy_d_nxt = ready_s;
    if (sys_init) begin
      flag_nxt = 1'b0;
      ie_nxt = 1'b0;
      strobe_nxt = 1'b0;
    end else begin
      if (tick1 && dev_sel && ((sub == `LPC_SUB_CLF) ||
                               (sub == `LPC_SUB_CLF_LOAD))) begin
        flag_nxt = 1'b0;
      end
      if (tick1 && dev_sel && (sub == `LPC_SUB_SIE)) begin
        ie_nxt = 1'b1;
      end else if (tick1 && (is_clr_all ||
                             (dev_sel && (sub == `LPC_SUB_CIE)))) begin
        ie_nxt = 1'b0;
      end
      if (tick3 && is_load) begin
        buf_nxt = ac_r[6:0];
      end
      if (req_fall) begin
        strobe_nxt = 1'b0;
      end
      if (tick_end && is_load) begin
        strobe_nxt = 1'b1;
      end
    end
    if (req_rise) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
      ie_r <= 1'b0;
      buf_r <= `LPC_BUF_RST;
      strobe_r <= 1'b0;
      req_d_r <= 1'b0;
      rdy_d_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      ie_r <= ie_nxt;
      buf_r <= buf_nxt;
      strobe_r <= strobe_nxt;
      req_d_r <= req_d_nxt;
      rdy_d_r <= rdy_d_nxt;
    end
  end

  // Register file and interrupt status
  always_comb begin
    st_word = 32'h0000_0000;
    st_word[`LPC_ST_FLAG] = flag_r;
    st_word[`LPC_ST_IE] = ie_r;
    st_word[`LPC_ST_SKIP] = skip_r;
    st_word[`LPC_ST_READY] = ready_s;
    st_word[`LPC_ST_STROBE] = strobe_r;
    st_word[`LPC_ST_BUSY] = busy;
    if (paddr == `LPC_ADDR_CMD) begin
      rd_val = {20'h0_0000, code_r};
    end else if (paddr == `LPC_ADDR_AC) begin
      rd_val = {20'h0_0000, ac_r};
    end else if (paddr == `LPC_ADDR_STATUS) begin
      rd_val = st_word;
    end else if (paddr == `LPC_ADDR_ISTAT) begin
      rd_val = {29'h0000_0000, istat_r};
    end else if (paddr == `LPC_ADDR_IMASK) begin
      rd_val = {29'h0000_0000, imask_r};
    end else begin
      rd_val = 32'h0000_0000;
    end
    prdata_nxt = prdata_r;
    if (psel && !penable && !pwrite) begin
      prdata_nxt = rd_val;
    end
    ac_nxt = ac_r;
    imask_nxt = imask_r;
    istat_nxt = istat_r;
    if (wr_ok && (paddr == `LPC_ADDR_AC)) begin
      ac_nxt = pwdata[11:0];
    end
    if (wr_ok && (paddr == `LPC_ADDR_IMASK)) begin
      imask_nxt = pwdata[`LPC_IRQ_W-1:0];
    end
    if (wr_ok && (paddr == `LPC_ADDR_ISTAT)) begin
      istat_nxt = istat_r & ~pwdata[`LPC_IRQ_W-1:0];
    end
    if (req_rise) begin
      istat_nxt[`LPC_IRQ_FLAG] = 1'b1;
    end
    if (rdy_fall) begin
      istat_nxt[`LPC_IRQ_ERR] = 1'b1;
    end
    if (tick_end) begin
      istat_nxt[`LPC_IRQ_DONE] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_r <= `LPC_AC_RST;
      imask_r <= `LPC_MASK_RST;
      istat_r <= '0;
      prdata_r <= 32'h0000_0000;
    end else begin
      ac_r <= ac_nxt;
      imask_r <= imask_nxt;
      istat_r <= istat_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Outputs
  assign prdata = prdata_r;
  assign irq = |(istat_r & imask_r);
  assign bus_irq_n = !(ie_r && (flag_r || !ready_s));
  assign iot_skip = iot_skip_r;
  assign char_data = buf_r;
  assign data_strobe = strobe_r;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_flag_set;
    req_rise |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set by char_request");

  property p_irq_on;
    ie_r && flag_r |-> !bus_irq_n;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled flag gives no bus request");

  property p_irq_off;
    !ie_r |-> bus_irq_n;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("bus request while disabled");

  property p_skip_flag;
    tick1 && dev_sel && (sub == `LPC_SUB_SKF) && flag_r
      |=> skip_r ##[1:300] iot_skip;
  endproperty
  a_skip_flag: assert property (p_skip_flag)
    else $error("skip on flag missing");

  property p_clear_flag;
    tick1 && dev_sel && (sub == `LPC_SUB_CLF) && !req_rise
      |=> !flag_r && (ie_r == $past(ie_r)) && (buf_r == $past(buf_r));
  endproperty
  a_clear_flag: assert property (p_clear_flag)
    else $error("clear flag wrong");

  property p_skip_err;
    tick1 && dev_sel && (sub == `LPC_SUB_SKE)
      |=> skip_r == !$past(ready_s);
  endproperty
  a_skip_err: assert property (p_skip_err)
    else $error("skip on error wrong");

  property p_ie_ctl;
    tick1 && !sys_init && (is_clr_all || (dev_sel && (sub == `LPC_SUB_CIE)))
      |=> !ie_r;
  endproperty
  a_ie_ctl: assert property (p_ie_ctl)
    else $error("enable not cleared");

  property p_buf_load;
    tick3 && is_load && !sys_init |=> char_data == $past(ac_r[6:0]);
  endproperty
  a_buf_load: assert property (p_buf_load)
    else $error("buffer not loaded");

  property p_strobe;
    tick_end && is_load && !sys_init |=> data_strobe;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe not set at trailing edge");

  property p_clf_load;
    tick1 && dev_sel && (sub == `LPC_SUB_CLF_LOAD) && !req_rise
      |=> !flag_r;
  endproperty
  a_clf_load: assert property (p_clf_load)
    else $error("6666 did not clear flag");

  property p_ignore;
    tick1 && !dev_sel && !is_clr_all && !sys_init |=> ie_r == $past(ie_r);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("foreign instruction acted");

  c_load: cover property (tick_end && is_load ##[1:300] req_fall);
  c_skip: cover property (iot_skip);
  c_irq: cover property (!bus_irq_n);
  c_stall: cover property (cmd_hit && access && busy);

endmodule

// file: sim/lpc_printer_model.sv
// Printer model: ready, character request and character capture
`timescale 1ns/1ns
module lpc_printer_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control from the bench
  input wire logic online,
  input wire logic fault,
  // Printer port
  input wire logic [6:0] char_data,
  input wire logic data_strobe,
  output logic ready,
  output logic char_request,
  output logic [6:0] got
);
  int wait_c;
  assign ready = !fault;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      char_request <= 1'b0;
      wait_c <= 10;
      got <= 7'h00;
    end else if (char_request && data_strobe) begin
      // Take the character, drop the request, then pause a random time
      got <= char_data;
      char_request <= 1'b0;
      // Pause outlasts a flag clear issued right after the load
      wait_c <= $urandom_range(200, 150);
    end else if (!online || fault) begin
      char_request <= 1'b0;
    end else if (wait_c > 0) begin
      if (!data_strobe) begin
        wait_c <= wait_c - 1;
      end
    end else begin
      char_request <= 1'b1;
    end
  end
endmodule

// file: sim/line_printer_control_tb.sv
// Testbench of the line printer control
`timescale 1ns/1ns
`include "lpc_consts.svh"
module line_printer_control_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sys_init = 0, irq, bus_irq_n, iot_skip;
  logic ready, char_request, data_strobe, online = 0, fault = 0;
  logic [6:0] char_data, got;
  logic flag = 0, ie = 0;
  logic [31:0] v;
  logic e;
  int errors = 0, num_checks = 0, skips = 0;
  logic [6:0] chars[$];
  logic [11:0] loads[2] = '{12'hDB4, 12'hDB6};
  localparam logic [11:0] ST = `LPC_ADDR_STATUS;

  always #2 pclk = ~pclk;
  always @(posedge pclk) if (iot_skip === 1'b1) skips <= skips + 1;

  lpc_line_printer_ctl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_init(sys_init), .irq(irq), .bus_irq_n(bus_irq_n),
    .iot_skip(iot_skip), .ready(ready), .char_request(char_request),
    .char_data(char_data), .data_strobe(data_strobe));
  lpc_printer_model prn (.pclk(pclk), .presetn(presetn), .online(online),
    .fault(fault), .char_data(char_data), .data_strobe(data_strobe),
    .ready(ready), .char_request(char_request), .got(got));

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 500);
    if (n >= 500) begin errors++; summarize(); end
    r = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, v, e);
    check(v, x);
  endtask
  task automatic poll(input int bit_i, input logic want);
    int n;
    n = 0;
    do begin apb(1'b0, ST, 32'h0, v, e); n++; end
    while (v[bit_i] !== want && n < 100);
    if (n >= 100) begin errors++; summarize(); end
  endtask
  task automatic exec(input logic [11:0] c);
    int s0;
    logic sk;
    s0 = skips;
    sk = 0;
    if (c[11:3] == 9'h1B6) begin
      case (c[2:0])
        3'h1: sk = flag;
        3'h2, 3'h6: flag = 0;
        3'h3: sk = fault;
        3'h5: ie = 1;
        3'h7: ie = 0;
        default: ;
      endcase
    end
    if (c == 12'hC07) ie = 0;
    wr(`LPC_ADDR_CMD, {20'h0, c});
    poll(5, 1'b0);
    check(32'(skips - s0), {31'h0, sk});
    check(v[1:0], {ie, flag});
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    // Printer pins need two edges through the synchroniser
    repeat (3) @(posedge pclk);
    void'($urandom(28199));
    rdc(ST, 32'h8);
    rdc(12'h014, 32'h0);
    check(e, 1);
    wr(`LPC_ADDR_IMASK, 32'h7);
    rdc(`LPC_ADDR_IMASK, 32'h7);
    online <= 1;
    poll(0, 1'b1);
    flag = 1;
    check(bus_irq_n, 1);
    check(irq, 1);
    exec(12'hDB1);
    // The exec of D91 stalls on pready until the D91 written here has finished
    wr(`LPC_ADDR_CMD, 32'hD91);
    exec(12'hD91);
    exec(12'hDB5);
    check(bus_irq_n, 0);
    foreach (loads[i]) begin
      chars.push_back(7'($urandom));
      wr(`LPC_ADDR_AC, {25'h0, chars[$]});
      exec(loads[i]);
      check(char_data, chars[$]);
      check(got, chars.pop_front());
      // Clear while the printer pauses; next load waits for a new request
      exec(12'hDB2);
      poll(0, 1'b1);
      flag = 1;
      check(data_strobe, 0);
    end
    exec(12'hDB2);
    exec(12'hDB1);
    exec(12'hDB3);
    fault <= 1;
    repeat (5) @(posedge pclk);
    exec(12'hDB3);
    check(bus_irq_n, 0);
    fault <= 0;
    poll(0, 1'b1);
    flag = 1;
    exec(12'hDB7);
    check(bus_irq_n, 1);
    exec(12'hDB5);
    exec(12'hC07);
    exec(12'hDB5);
    sys_init <= 1;
    @(posedge pclk);
    sys_init <= 0;
    flag = 0;
    ie = 0;
    rdc(ST, 32'h8);
    check(bus_irq_n, 1);
    wr(`LPC_ADDR_ISTAT, 32'h7);
    rdc(`LPC_ADDR_ISTAT, 32'h0);
    check(irq, 0);
    wr(`LPC_ADDR_IMASK, 32'h2);
    fault <= 1;
    repeat (6) @(posedge pclk);
    check(irq, 1);
    rdc(`LPC_ADDR_ISTAT, 32'h2);
    wr(`LPC_ADDR_ISTAT, 32'h2);
    @(posedge pclk);
    check(irq, 0);
    fault <= 0;
    summarize();
  end
endmodule
